// file: logic/dst_pkg.sv
package dst_pkg;

    // ------------------------------------------------------------------
    // Register map (8-bit registers on the serial interface)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] REG_MODE_ST = 8'h01;
    localparam logic [7:0] REG_CFG_02 = 8'h02;
    localparam logic [7:0] REG_SYNC_MASK = 8'h03;
    localparam logic [7:0] REG_ST_STATUS = 8'h04;
    localparam logic [7:0] REG_SYNC_BEHAV = 8'h05;
    localparam logic [7:0] REG_CFG_06 = 8'h06;
    localparam logic [7:0] REG_CFG_0C = 8'h0c;
    localparam logic [7:0] REG_CFG_0D = 8'h0d;
    localparam logic [7:0] REG_SDO_FUNC = 8'h0e;
    localparam logic [7:0] REG_CFG_0F = 8'h0f;
    localparam int REG_SLOTS = 16;
    localparam int IDX_W = 4;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_ST_ENABLE = 3;
    localparam int BIT_ERR_MASK = 2;
    localparam int BIT_ST_ERROR = 0;
    localparam int SDO_SEL_HI = 7;
    localparam int SDO_SEL_LO = 5;
    localparam logic [2:0] SDO_SEL_ST_ERR = 3'h5;

    // ------------------------------------------------------------------
    // Test cycle and pattern
    // ------------------------------------------------------------------
    localparam int SAMPLE_W = 16;
    localparam int CNT_W = 19;
    localparam int MAX_CYCLE_CLKS = 400000;
    localparam int CHECK_OVERHEAD = 2;
    localparam int CYCLE_LEN_DEF = 262144;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;
    // Arbitrary value; the real hardwired constant is set per chip
    localparam logic [15:0] EXPECTED_DEF = 16'h0000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dst_reg_req_t;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_RUN,
        ST_DRAIN,
        ST_CHECK
    } dst_state_t;

endpackage

// file: logic/dst_lfsr.sv
`timescale 1ns/10ps
module dst_lfsr #(
    parameter int W = 16,
    parameter logic [W-1:0] SEED = 16'hace1,
    parameter logic [W-1:0] TAPS = 16'hb400
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic step,
    output logic [W-1:0] q
);
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    // ------------------------------------------------------------------
    // Galois shift, reload wins over step
    // ------------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        if (load) begin
            nxt_q = SEED;
        end else if (step) begin
            nxt_q = q_ff[0] ? ((q_ff >> 1) ^ TAPS) : (q_ff >> 1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= SEED;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;
endmodule

// file: logic/dst_csum.sv
`timescale 1ns/10ps
module dst_csum #(
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic en,
    input wire logic [W-1:0] din,
    output logic [W-1:0] sum
);
    logic [W-1:0] sum_ff;
    logic [W-1:0] nxt_sum;

    // ------------------------------------------------------------------
    // Rotate-and-xor; rotation keeps word order significant
    // ------------------------------------------------------------------
    always_comb begin
        nxt_sum = sum_ff;
        if (clear) begin
            nxt_sum = '0;
        end else if (en) begin
            nxt_sum = {sum_ff[W-2:0], sum_ff[W-1]} ^ din;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sum_ff <= '0;
        end else begin
            sum_ff <= nxt_sum;
        end
    end

    assign sum = sum_ff;
endmodule

// file: logic/dst_top.sv
`timescale 1ns/10ps
module dst_top #(
    parameter int CYCLE_LEN = dst_pkg::CYCLE_LEN_DEF,
    parameter logic [15:0] EXPECTED = dst_pkg::EXPECTED_DEF
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire dst_pkg::dst_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] lvds_data,
    input wire logic lvds_sync_input,
    input wire logic three_wire_mode,
    output logic [15:0] chain_out,
    output logic self_test_active,
    output logic sdo_out,
    output logic sdo_oe
);
    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] regs_ff [dst_pkg::REG_SLOTS];
    logic [7:0] nxt_regs [dst_pkg::REG_SLOTS];
    logic [7:0] reg_rdata_ff;
    logic [7:0] nxt_reg_rdata;
    logic self_test_error_ff;
    logic nxt_self_test_error;
    logic addr_mapped;
    logic err_clear_wr;
    logic err_set;
    logic [dst_pkg::IDX_W-1:0] idx;
    logic self_test_enable;
    logic self_test_error_mask;
    logic [2:0] serial_out_function_select;

    dst_pkg::dst_state_t state_ff;
    dst_pkg::dst_state_t nxt_state;
    logic [dst_pkg::CNT_W-1:0] cnt_ff;
    logic [dst_pkg::CNT_W-1:0] nxt_cnt;
    logic [15:0] chain_ff;
    logic [15:0] nxt_chain;
    logic csum_en_ff;
    logic nxt_csum_en;
    logic run_go;
    logic restart;
    logic [15:0] pattern;
    logic [15:0] csum;
    logic mismatch;

    localparam logic [dst_pkg::CNT_W-1:0] LAST_CNT =
        dst_pkg::CNT_W'(CYCLE_LEN - 1);

    assign idx = reg_req.addr[dst_pkg::IDX_W-1:0];

    always_comb begin
        case (reg_req.addr)
            dst_pkg::REG_MODE_ST, dst_pkg::REG_CFG_02,
            dst_pkg::REG_SYNC_MASK, dst_pkg::REG_ST_STATUS,
            dst_pkg::REG_SYNC_BEHAV, dst_pkg::REG_CFG_06,
            dst_pkg::REG_CFG_0C, dst_pkg::REG_CFG_0D,
            dst_pkg::REG_SDO_FUNC, dst_pkg::REG_CFG_0F: begin
                addr_mapped = 1'b1;
            end
            default: begin
                addr_mapped = 1'b0;
            end
        endcase
    end

    assign self_test_enable =
        regs_ff[dst_pkg::REG_MODE_ST[dst_pkg::IDX_W-1:0]]
            [dst_pkg::BIT_ST_ENABLE];
    assign self_test_error_mask =
        regs_ff[dst_pkg::REG_SYNC_MASK[dst_pkg::IDX_W-1:0]]
            [dst_pkg::BIT_ERR_MASK];
    assign serial_out_function_select =
        regs_ff[dst_pkg::REG_SDO_FUNC[dst_pkg::IDX_W-1:0]]
            [dst_pkg::SDO_SEL_HI:dst_pkg::SDO_SEL_LO];

    assign err_clear_wr = reg_req.wr &&
        (reg_req.addr == dst_pkg::REG_ST_STATUS) &&
        !reg_req.wdata[dst_pkg::BIT_ST_ERROR];

    always_comb begin
        nxt_regs = regs_ff;
        nxt_reg_rdata = reg_rdata_ff;
        if (reg_req.wr && addr_mapped &&
                reg_req.addr != dst_pkg::REG_ST_STATUS) begin
            nxt_regs[idx] = reg_req.wdata;
        end
        // Unmapped reads answer zero; status shows only the error bit
        if (reg_req.rd) begin
            nxt_reg_rdata = 8'h00;
            if (reg_req.addr == dst_pkg::REG_ST_STATUS) begin
                nxt_reg_rdata[dst_pkg::BIT_ST_ERROR] = self_test_error_ff;
            end else if (addr_mapped) begin
                nxt_reg_rdata = regs_ff[idx];
            end
        end
        nxt_self_test_error = self_test_error_ff;
        if (err_set) begin
            nxt_self_test_error = 1'b1;
        end else if (err_clear_wr) begin
            nxt_self_test_error = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < dst_pkg::REG_SLOTS; i++) begin
                regs_ff[i] <= dst_pkg::REG_RESET_VAL;
            end
            reg_rdata_ff <= 8'h00;
            self_test_error_ff <= 1'b0;
        end else begin
            regs_ff <= nxt_regs;
            reg_rdata_ff <= nxt_reg_rdata;
            self_test_error_ff <= nxt_self_test_error;
        end
    end

    // ------------------------------------------------------------------
    // Test sequencer
    // ------------------------------------------------------------------
    // Enable bit plus sync keep the test running
    assign run_go = self_test_enable && lvds_sync_input;
    assign restart = (state_ff != dst_pkg::ST_RUN) &&
        (nxt_state == dst_pkg::ST_RUN);
    assign mismatch = (csum != EXPECTED);
    // Compare once the last word is absorbed
    assign err_set = (state_ff == dst_pkg::ST_CHECK) && mismatch &&
        !self_test_error_mask;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            dst_pkg::ST_OFF: begin
                nxt_cnt = '0;
                if (run_go) begin
                    nxt_state = dst_pkg::ST_RUN;
                end
            end
            dst_pkg::ST_RUN: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (!run_go) begin
                    nxt_state = dst_pkg::ST_OFF;
                end else if (cnt_ff == LAST_CNT) begin
                    nxt_state = dst_pkg::ST_DRAIN;
                end
            end
            dst_pkg::ST_DRAIN: begin
                nxt_state = run_go ? dst_pkg::ST_CHECK : dst_pkg::ST_OFF;
            end
            dst_pkg::ST_CHECK: begin
                nxt_cnt = '0;
                nxt_state = run_go ? dst_pkg::ST_RUN : dst_pkg::ST_OFF;
            end
            default: begin
                nxt_state = dst_pkg::ST_OFF;
            end
        endcase
    end

    // Whole test runs on mclk, the sample clock itself
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= dst_pkg::ST_OFF;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    always_comb begin
        nxt_csum_en = (state_ff == dst_pkg::ST_RUN);
        // Pattern source only in ST_RUN, not in ST_DRAIN or ST_CHECK
        if (state_ff == dst_pkg::ST_RUN) begin
            nxt_chain = pattern;
        end else if (!lvds_sync_input || self_test_enable) begin
            nxt_chain = '0;
        end else begin
            nxt_chain = lvds_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chain_ff <= '0;
            csum_en_ff <= 1'b0;
        end else begin
            chain_ff <= nxt_chain;
            csum_en_ff <= nxt_csum_en;
        end
    end

    dst_lfsr #(
        .W(dst_pkg::SAMPLE_W),
        .SEED(dst_pkg::LFSR_SEED),
        .TAPS(dst_pkg::LFSR_TAPS)
    ) u_lfsr (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(restart),
        .step(state_ff == dst_pkg::ST_RUN),
        .q(pattern)
    );

    dst_csum #(
        .W(dst_pkg::SAMPLE_W)
    ) u_csum (
        .mclk(mclk),
        .rst_n(rst_n),
        .clear(restart),
        .en(csum_en_ff),
        .din(chain_ff),
        .sum(csum)
    );

    assign chain_out = chain_ff;
    assign reg_rdata = reg_rdata_ff;
    assign self_test_active = (state_ff != dst_pkg::ST_OFF);
    // Error flag on SERIAL_DATA_OUTPUT_PIN when selected in 3-wire mode
    assign sdo_oe = three_wire_mode &&
        (serial_out_function_select == dst_pkg::SDO_SEL_ST_ERR);
    assign sdo_out = sdo_oe && self_test_error_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [dst_pkg::CNT_W-1:0] age_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            age_ff <= '0;
        end else if (restart || state_ff == dst_pkg::ST_OFF) begin
            age_ff <= '0;
        end else begin
            age_ff <= age_ff + 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_enter_test: assert property (
        state_ff == dst_pkg::ST_OFF && self_test_enable && lvds_sync_input
        |=> state_ff == dst_pkg::ST_RUN)
        else $error("self test did not start");
    chk_leave_test: assert property (
        !self_test_enable |=> state_ff == dst_pkg::ST_OFF)
        else $error("self test kept running without enable");
    chk_pattern_src: assert property (
        state_ff == dst_pkg::ST_RUN |=> chain_ff == $past(pattern))
        else $error("chain not fed by pattern during test");
    chk_sync_zero: assert property (
        !lvds_sync_input && state_ff != dst_pkg::ST_RUN
        |=> chain_ff == 16'h0000)
        else $error("zeros not inserted with sync low");
    chk_cycle_bound: assert property (
        age_ff < dst_pkg::CNT_W'(dst_pkg::MAX_CYCLE_CLKS))
        else $error("test cycle exceeded bound");
    chk_auto_restart: assert property (
        state_ff == dst_pkg::ST_CHECK && run_go
        |=> state_ff == dst_pkg::ST_RUN && pattern == dst_pkg::LFSR_SEED
            && csum == 16'h0000)
        else $error("no clean restart after check");
    chk_err_cause: assert property (
        $rose(self_test_error_ff) |-> $past(state_ff) == dst_pkg::ST_CHECK
        && $past(mismatch) && !$past(self_test_error_mask))
        else $error("error flag set without masked-off mismatch");
    chk_err_sticky: assert property (
        self_test_error_ff && !err_clear_wr |=> self_test_error_ff)
        else $error("error flag dropped without zero write");
    chk_err_clear: assert property (
        err_clear_wr && !err_set |=> !self_test_error_ff)
        else $error("zero write did not clear error flag");
    chk_mask_holds: assert property (
        self_test_error_mask && !self_test_error_ff
        |=> !self_test_error_ff)
        else $error("masked mismatch set the flag");
    chk_sdo_route: assert property (
        sdo_oe |-> sdo_out == self_test_error_ff)
        else $error("SERIAL_DATA_OUTPUT_PIN does not show error flag");

    cov_error_seen: cover property ($rose(self_test_error_ff));
    cov_loop_twice: cover property (
        state_ff == dst_pkg::ST_CHECK ##1 state_ff == dst_pkg::ST_RUN);
    cov_clear_flag: cover property (
        self_test_error_ff ##1 !self_test_error_ff);
endmodule

// file: sim/dst_host.sv
`timescale 1ns/10ps
module dst_host (
    input wire logic mclk,
    output dst_pkg::dst_reg_req_t reg_req,
    output logic lvds_sync_input
);
    // ------------------------------------------------------------------
    // Self test register settings, first entry in the top byte
    // ------------------------------------------------------------------
    localparam logic [79:0] P_ADDR = 80'h01_02_03_04_05_06_0c_0d_0e_0f;
    localparam logic [79:0] P_VAL = 80'h18_ea_b0_00_06_0f_0a_55_0a_aa;

    initial begin
        reg_req = '0;
        lvds_sync_input = 1'b0;
    end

    // Strobe stays up for exactly one sampling edge, then bus goes idle
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge mclk);
        reg_req <= '0;
    endtask

    task automatic rd(input logic [7:0] addr);
        @(posedge mclk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge mclk);
        reg_req <= '0;
    endtask

    task automatic program_test();
        for (int i = 9; i >= 0; i--) begin
            wr(P_ADDR[8*i+:8], P_VAL[8*i+:8]);
        end
    endtask

    task automatic set_sync(input logic v);
        @(posedge mclk);
        lvds_sync_input <= v;
    endtask
endmodule

// file: sim/dst_top_test.sv
`timescale 1ns/10ps
module dst_top_test;
    localparam int CL = 16;
    localparam logic [79:0] T_ADDR = 80'h01_02_03_04_05_06_0c_0d_0e_0f;
    localparam logic [79:0] T_VAL = 80'h18_ea_b0_00_06_0f_0a_55_0a_aa;

    function automatic logic [15:0] lfsr_next(input logic [15:0] q);
        return q[0] ? ((q >> 1) ^ dst_pkg::LFSR_TAPS) : (q >> 1);
    endfunction

    function automatic logic [15:0] csum_of(input int n);
        logic [15:0] q;
        logic [15:0] s;
        q = dst_pkg::LFSR_SEED;
        s = 16'h0000;
        for (int i = 0; i < n; i++) begin
            s = {s[14:0], s[15]} ^ q;
            q = lfsr_next(q);
        end
        return s;
    endfunction

    // One instance expects the true sum, the other can never match it
    localparam logic [15:0] GOOD = csum_of(CL);

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] lvds_data = 16'h0000;
    logic three_wire_mode = 1'b0;
    logic sync;
    dst_pkg::dst_reg_req_t req;
    logic [7:0] rdata_g, rdata_b;
    logic [15:0] chain_g, chain_b;
    logic act_g, act_b, sdo_g, sdo_b, oe_g, oe_b;
    logic rd_seen = 1'b0;
    logic [15:0] exp_q[$];
    logic [15:0] w;
    int seed = 32'h3902;
    int mismatches = 0;
    int cmp_count = 0;
    int n;

    always #4 mclk = ~mclk;

    dst_host host (.mclk(mclk), .reg_req(req), .lvds_sync_input(sync));

    dst_top #(.CYCLE_LEN(CL), .EXPECTED(GOOD)) dut (
        .mclk(mclk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata_g),
        .lvds_data(lvds_data), .lvds_sync_input(sync),
        .three_wire_mode(three_wire_mode), .chain_out(chain_g),
        .self_test_active(act_g), .sdo_out(sdo_g), .sdo_oe(oe_g));

    dst_top #(.CYCLE_LEN(CL), .EXPECTED(~GOOD)) dut_bad (
        .mclk(mclk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata_b),
        .lvds_data(lvds_data), .lvds_sync_input(sync),
        .three_wire_mode(three_wire_mode), .chain_out(chain_b),
        .self_test_active(act_b), .sdo_out(sdo_b), .sdo_oe(oe_b));

    // ------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic flags(input logic [3:0] exp);
        check({12'h000, oe_g, sdo_g, oe_b, sdo_b}, {12'h000, exp});
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [15:0] exp);
        exp_q.push_back(exp);
        host.rd(a);
    endtask

    task automatic wait_clk(input int k);
        repeat (k) @(negedge mclk);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        rd_seen <= req.rd;
        lvds_data <= 16'($random(seed));
    end

    always @(negedge mclk) begin
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0) begin
                check({rdata_g, rdata_b}, 16'hxxxx);
            end else begin
                check({rdata_g, rdata_b}, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        // clock runs, reset pulse before programming
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            rd_exp(T_ADDR[8*i+:8], 16'h0000);
        end
        host.wr(8'h07, 8'($random(seed)));
        rd_exp(8'h07, 16'h0000);
        $display("test reset_values done");

        host.program_test();
        for (int i = 0; i < 10; i++) begin
            rd_exp(T_ADDR[8*i+:8], {2{T_VAL[8*i+:8]}});
        end
        w = 16'($random(seed));
        host.wr(8'h06, w[7:0]);
        rd_exp(8'h06, {2{w[7:0]}});
        host.wr(8'h06, 8'h0f);
        host.wr(8'h0e, 8'haa);
        @(posedge mclk) three_wire_mode <= 1'b1;
        wait_clk(2);
        flags(4'b1010);
        $display("test program done");

        host.set_sync(1'b1);
        n = 0;
        w = dst_pkg::LFSR_SEED;
        while (n < 40 && sdo_b !== 1'b1) begin
            @(negedge mclk);
            n++;
            if (n >= 3 && n < 3 + CL) begin
                check(chain_g, w);
                check(chain_b, w);
                w = lfsr_next(w);
            end
        end
        check(16'(n), 16'(CL + 4));
        flags(4'b1011);
        wait_clk(CL + 2);
        rd_exp(8'h04, 16'h0001);
        $display("test first_cycle done");

        host.wr(8'h01, 8'h10);
        wait_clk(3);
        check({14'h0, act_g, act_b}, 16'h0000);
        wait_clk(40);
        rd_exp(8'h04, 16'h0001);
        host.wr(8'h04, 8'h01);
        rd_exp(8'h04, 16'h0001);
        host.wr(8'h04, 8'h00);
        rd_exp(8'h04, 16'h0000);
        wait_clk(1);
        flags(4'b1010);
        $display("test sticky done");

        host.wr(8'h01, 8'h18);
        wait_clk(3);
        check({14'h0, act_g, act_b}, 16'h0003);
        wait_clk(CL + 6);
        host.wr(8'h04, 8'h00);
        wait_clk(CL + 6);
        rd_exp(8'h04, 16'h0001);
        $display("test repeat done");

        host.wr(8'h03, 8'hb4);
        host.wr(8'h04, 8'h00);
        wait_clk(2 * CL + 8);
        rd_exp(8'h04, 16'h0000);
        rd_exp(8'h03, 16'hb4b4);
        host.wr(8'h03, 8'hb0);
        $display("test mask done");

        host.set_sync(1'b0);
        @(posedge mclk) three_wire_mode <= 1'b0;
        wait_clk(3);
        check({14'h0, act_g, act_b}, 16'h0000);
        check(chain_g | chain_b, 16'h0000);
        flags(4'b0000);
        $display("test sync_low done");

        host.set_sync(1'b1);
        wait_clk(7);
        @(posedge mclk) rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rd_exp(8'h01, 16'h0000);
        rd_exp(8'h0e, 16'h0000);
        wait_clk(1);
        check({14'h0, act_g, act_b}, 16'h0000);
        $display("test second_reset done");
        conclude();
    end
endmodule
